// File: include/adc_ctrl_regs.vh
// Purpose: register map, field positions and timing counts of the converter control block
// Assumes: APB word addressing, 8-bit registers in the low byte of each word
// Notes:   shared by the design and the bench
//
// What this block does
// - result left-justified, high byte bits 9..2
// - result reads zero while converter disabled
// - start on start bit low-high-low sequence
// - results and busy flag are read-only
// - channel select bit picks pin 0/1
// - source field: 00/11 external, 01 bandgap, 10 amplifier
// - reference select: 0 analog supply, 1 regulator
// - amplifier supply: 0 regulator, 1 analog supply
// - base clock is the fast internal RC
// - bandgap enable bit powers bandgap reference
// - analog pin drops its I/O and pull-high
// - unimplemented bits read as zero
// - busy set at start, cleared with interrupt
// - enable must be high; wait power-on delay
// - conversion takes 4 sample + 10 convert clocks
`ifndef ADC_CTRL_REGS_VH
`define ADC_CTRL_REGS_VH

// ****************************************************************
// register byte addresses
// ****************************************************************
`define ADDR_RESULT_LOW     12'h000
`define ADDR_RESULT_HIGH    12'h004
`define ADDR_START_STATUS   12'h008
`define ADDR_SOURCE_CLOCK   12'h00c
`define ADDR_BANDGAP        12'h010
`define ADDR_IRQ_STATUS     12'h014
`define ADDR_IRQ_MASK       12'h018

// ****************************************************************
// field positions
// ****************************************************************
`define BIT_START           7
`define BIT_BUSY            6
`define BIT_ENABLE          5
`define BIT_BUFMODE         4
`define BIT_CHSEL           0
`define BIT_REFSEL          4
`define BIT_OPASUP          3
`define BIT_BGEN            3
`define BIT_IRQ_DONE        0
`define MASK_START_STATUS   8'hb1
`define MASK_SOURCE_CLOCK   8'h7f
`define MASK_BANDGAP        8'h08
`define MASK_IRQ            8'h01

// ****************************************************************
// source codes and timing
// ****************************************************************
`define SRC_BANDGAP         2'h1
`define SRC_AMPLIFIER       2'h2
`define SAMPLE_CYCLES       4'h4
`define TOTAL_CYCLES        4'he
`define RESET_BYTE          8'h00

`endif

// File: hw/adc_ctrl.v
// Purpose: control and register logic of a 10-bit converter, APB slave
// Assumes: clk is the fast internal RC base clock; analog core answers on its result port
// Notes:   one level interrupt output, sticky done flag cleared by writing one
//
// Our own choices: the APB interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"

module adc_ctrl #(
  parameter DIV_W = 3
) (
  // clock and reset
  input  wire        clk,
  input  wire        sys_rst,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire        pready,
  output wire        pslverr,
  output reg  [31:0] prdata,
  // analog core
  input  wire [9:0]  core_result,
  output reg         core_power,
  output reg         core_sample,
  output reg         core_convert,
  output reg         core_clk_tick,
  output reg         ref_regulator,
  output reg         opamp_on_analog_supply,
  output reg         bandgap_power,
  output reg         prebuffer_on,
  output reg  [1:0]  input_route,
  output reg  [1:0]  pin_analog_mode,
  // interrupt
  output wire        irq
);

  // ****************************************************************
  // registers
  // ****************************************************************
  reg  [7:0]       start_status_reg;
  reg  [7:0]       source_clock_reg;
  reg  [7:0]       bandgap_reg;
  reg  [9:0]       result_reg;
  reg  [7:0]       irq_status_reg;
  reg  [7:0]       irq_mask_reg;
  reg              busy_reg;
  reg              start_armed_reg;
  reg  [6:0]       div_count_reg;
  reg  [3:0]       conv_count_reg;
  wire             wr_en;
  wire             rd_en;
  wire             enable;
  wire             launch;
  wire             tick;
  wire             done;
  wire [6:0]       div_limit;

  localparam [1:0] ROUTE_EXT_PIN0  = 2'h0;
  localparam [1:0] ROUTE_EXT_PIN1  = 2'h1;
  localparam [1:0] ROUTE_BANDGAP   = 2'h2;
  localparam [1:0] ROUTE_AMPLIFIER = 2'h3;

  // address decode, used for read and write
  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `ADDR_RESULT_LOW) || (a == `ADDR_RESULT_HIGH) ||
                  (a == `ADDR_START_STATUS) || (a == `ADDR_SOURCE_CLOCK) ||
                  (a == `ADDR_BANDGAP) || (a == `ADDR_IRQ_STATUS) ||
                  (a == `ADDR_IRQ_MASK);
    end
  endfunction

  assign pready  = 1'b1;                        // zero wait states
  assign pslverr = psel & penable & ~is_mapped(paddr);
  assign wr_en   = psel & penable & pwrite & is_mapped(paddr);
  assign rd_en   = psel & ~penable & ~pwrite;
  assign enable  = start_status_reg[`BIT_ENABLE];

  // start launches when the bit falls after having risen
  // the same write must keep enable high, or the core would be sampled while powering down
  assign launch = wr_en & (paddr == `ADDR_START_STATUS) & start_armed_reg
                  & ~pwdata[`BIT_START] & pwdata[`BIT_ENABLE] & enable & ~busy_reg;

  // ****************************************************************
  // control registers
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      start_status_reg <= `RESET_BYTE;
      source_clock_reg <= `RESET_BYTE;
      bandgap_reg      <= `RESET_BYTE;
      irq_mask_reg     <= `RESET_BYTE;
      start_armed_reg  <= 1'b0;
    end
    else if (wr_en)
    begin
      case (paddr)
        `ADDR_START_STATUS:
        begin
          // busy bit is not writable
          start_status_reg <= pwdata[7:0] & `MASK_START_STATUS;
          start_armed_reg  <= pwdata[`BIT_START];
        end
        `ADDR_SOURCE_CLOCK: source_clock_reg <= pwdata[7:0] & `MASK_SOURCE_CLOCK;
        `ADDR_BANDGAP:      bandgap_reg      <= pwdata[7:0] & `MASK_BANDGAP;
        `ADDR_IRQ_MASK:     irq_mask_reg     <= pwdata[7:0] & `MASK_IRQ;
        default:            irq_mask_reg     <= irq_mask_reg;
      endcase
    end
  end

  // ****************************************************************
  // conversion clock divider: base / 2^n
  // ****************************************************************
  assign div_limit = (7'h01 << source_clock_reg[DIV_W-1:0]) - 7'h01;

  always @(posedge clk)
  begin
    if (sys_rst || !busy_reg)
      div_count_reg <= 7'h00;
    else if (div_count_reg >= div_limit)
      div_count_reg <= 7'h00;
    else
      div_count_reg <= div_count_reg + 7'h01;
  end

  // no tick once enable drops, so a tick never follows core power going low
  assign tick = busy_reg & enable & (div_count_reg >= div_limit);
  assign done = tick & (conv_count_reg == `TOTAL_CYCLES - 4'h1);

  // ****************************************************************
  // conversion sequencer: 4 sample then 10 convert clocks
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst || !enable)
    begin
      busy_reg       <= 1'b0;
      conv_count_reg <= 4'h0;
    end
    else if (launch)
    begin
      busy_reg       <= 1'b1;
      conv_count_reg <= 4'h0;
    end
    else if (done)
    begin
      busy_reg       <= 1'b0;
      conv_count_reg <= 4'h0;
    end
    else if (tick)
      conv_count_reg <= conv_count_reg + 4'h1;
  end

  // result capture, forced zero while disabled
  always @(posedge clk)
  begin
    if (sys_rst || !enable)
      result_reg <= 10'h000;
    else if (done)
      result_reg <= core_result;
  end

  // ****************************************************************
  // interrupt: sticky done flag, set wins over clear
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
      irq_status_reg <= `RESET_BYTE;
    else
    begin
      if (wr_en && paddr == `ADDR_IRQ_STATUS)
        irq_status_reg <= irq_status_reg & ~pwdata[7:0];
      if (done)
        irq_status_reg[`BIT_IRQ_DONE] <= 1'b1;
    end
  end

  assign irq = |(irq_status_reg & irq_mask_reg);

  // ****************************************************************
  // analog steering outputs
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
    begin
      core_power             <= 1'b0;
      core_sample            <= 1'b0;
      core_convert           <= 1'b0;
      core_clk_tick          <= 1'b0;
      ref_regulator          <= 1'b0;
      opamp_on_analog_supply <= 1'b0;
      bandgap_power          <= 1'b0;
      prebuffer_on           <= 1'b0;
      input_route            <= ROUTE_EXT_PIN0;
      pin_analog_mode        <= 2'h0;
    end
    else
    begin
      core_power             <= enable;
      core_sample            <= busy_reg & (conv_count_reg < `SAMPLE_CYCLES);
      core_convert           <= busy_reg & (conv_count_reg >= `SAMPLE_CYCLES);
      core_clk_tick          <= tick;
      ref_regulator          <= source_clock_reg[`BIT_REFSEL];
      opamp_on_analog_supply <= source_clock_reg[`BIT_OPASUP];
      bandgap_power          <= bandgap_reg[`BIT_BGEN];
      prebuffer_on           <= start_status_reg[`BIT_BUFMODE];
      case (source_clock_reg[6:5])
        `SRC_BANDGAP:   input_route <= ROUTE_BANDGAP;
        `SRC_AMPLIFIER: input_route <= ROUTE_AMPLIFIER;
        default:        input_route <= start_status_reg[`BIT_CHSEL] ?
                                       ROUTE_EXT_PIN1 : ROUTE_EXT_PIN0;
      endcase
      // selected pin goes analog: I/O and pull-high released while enabled with an external source
      if (enable && (source_clock_reg[6:5] != `SRC_BANDGAP) &&
          (source_clock_reg[6:5] != `SRC_AMPLIFIER))
        pin_analog_mode <= start_status_reg[`BIT_CHSEL] ? 2'h2 : 2'h1;
      else
        pin_analog_mode <= 2'h0;
    end
  end

  // ****************************************************************
  // read data, registered in the setup cycle
  // ****************************************************************
  always @(posedge clk)
  begin
    if (sys_rst)
      prdata <= 32'h00000000;
    else if (rd_en)
    begin
      case (paddr)
        `ADDR_RESULT_LOW:   prdata <= {24'h000000, result_reg[1:0], 6'h00};
        `ADDR_RESULT_HIGH:  prdata <= {24'h000000, result_reg[9:2]};
        `ADDR_START_STATUS: prdata <= {24'h000000, start_status_reg[7],
                                       busy_reg, start_status_reg[5:0]};
        `ADDR_SOURCE_CLOCK: prdata <= {24'h000000, source_clock_reg};
        `ADDR_BANDGAP:      prdata <= {24'h000000, bandgap_reg};
        `ADDR_IRQ_STATUS:   prdata <= {24'h000000, irq_status_reg};
        `ADDR_IRQ_MASK:     prdata <= {24'h000000, irq_mask_reg};
        default:            prdata <= 32'h00000000;
      endcase
    end
  end

endmodule // adc_ctrl

// File: testbench/adc_ctrl_assertions.sv
// Purpose: port-level assertions of the converter control block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound into adc_ctrl at the foot of this file
`timescale 1ns/1ps
module adc_ctrl_checker (
  // clock and reset
  input wire        clk,
  input wire        sys_rst,
  // apb
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire        pslverr,
  // analog core
  input wire        core_power,
  input wire        core_sample,
  input wire        core_convert,
  input wire        core_clk_tick,
  input wire        bandgap_power,
  input wire [1:0]  input_route,
  input wire [1:0]  pin_analog_mode
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ****************************************************************
  // properties
  // ****************************************************************
  a_unmapped_err: assert property (psel && penable && paddr > 12'h018 |-> pslverr)
    else $error("no error on unmapped access");
  a_upper_zero: assert property (prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  a_phase_excl: assert property (!(core_sample && core_convert))
    else $error("sample and convert overlap");
  a_convert_after_sample: assert property ($rose(core_convert) |-> $past(core_sample))
    else $error("convert without sampling");
  a_tick_needs_power: assert property (core_clk_tick |-> core_power)
    else $error("tick while unpowered");
  a_pin_onehot: assert property ($onehot0(pin_analog_mode))
    else $error("two pins analog");
  a_internal_no_pin: assert property (input_route[1] |-> pin_analog_mode == 2'b00)
    else $error("pin routed with internal source");
  a_bandgap_by_write: assert property ((bandgap_power != $past(bandgap_power)) |->
    $past(psel && penable && pwrite && paddr == 12'h010) ||
    $past(psel && penable && pwrite && paddr == 12'h010, 2))
    else $error("bandgap changed without write");
  a_reset_zero: assert property (disable iff (1'b0) sys_rst |=>
    !core_power && !core_sample && input_route == 2'b00)
    else $error("outputs not cleared by reset");
endmodule // adc_ctrl_checker

bind adc_ctrl adc_ctrl_checker chk (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
  .core_power(core_power), .core_sample(core_sample), .core_convert(core_convert),
  .core_clk_tick(core_clk_tick), .bandgap_power(bandgap_power), .input_route(input_route),
  .pin_analog_mode(pin_analog_mode));

// File: testbench/adc_ctrl_tb.sv
// Purpose: self-checking bench of the converter control block
// Assumes: 50 MHz clock, apb slave answers with pready
// Notes:   analog core stood in by a fixed result value
`timescale 1ns/1ps
`include "adc_ctrl_regs.vh"
module adc_ctrl_tb;
  // ****************************************************************
  // signals
  // ****************************************************************
  reg         clk = 1'b0;
  reg         sys_rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [9:0]  core_result = 10'h2b5;
  wire        pready, pslverr, irq, pwr, smp, cnv, tck, refr, opa, bgp, pbuf;
  wire [31:0] prdata;
  wire [1:0]  route, pins;
  reg  [31:0] rd;
  reg         err;
  integer     fails = 0, n_tests = 0, i;
  time        t0;

  adc_ctrl dut (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .core_result(core_result), .core_power(pwr), .core_sample(smp), .core_convert(cnv),
    .core_clk_tick(tck), .ref_regulator(refr), .opamp_on_analog_supply(opa),
    .bandgap_power(bgp), .prebuffer_on(pbuf), .input_route(route), .pin_analog_mode(pins),
    .irq(irq));

  // clock and watchdog
  initial forever #10 clk = ~clk;
  initial
  begin
    #200000;
    fails = fails + 1;
    results;
  end

  // ****************************************************************
  // shared tasks
  // ****************************************************************
  task chk(input [31:0] s, input [31:0] e);
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      fails = fails + 1;
      $display("ERROR %0t got %h expected %h", $time, s, e);
    end
  endtask

  task bus(input w, input [11:0] a, input [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1)
      @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task results;
    $display("fails %0d n_tests %0d", fails, n_tests);
    if (fails == 0 && n_tests > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ****************************************************************
  // scenarios
  // ****************************************************************
  task t_access;
    for (i = 0; i < 7; i = i + 1)
    begin
      bus(0, 4 * i, 0);
      chk(rd, 0);
    end
    for (i = 0; i < 5; i = i + 1)
    begin
      bus(1, 4 * i, 32'hff);
      bus(0, 4 * i, 0);
      chk(rd, i == 2 ? 8'hb1 : i == 3 ? 8'h7f : i == 4 ? 8'h08 : 8'h00);
      bus(1, 4 * i, 0);
    end
    bus(0, 12'h01c, 0);
    chk(err, 1);
    chk(rd, 0);
  endtask

  task t_route;
    for (i = 0; i < 8; i = i + 1)
    begin
      bus(1, `ADDR_SOURCE_CLOCK, (i >> 1) << 5);
      bus(1, `ADDR_START_STATUS, 32'h20 | (i & 1));
      repeat (3) @(posedge clk);
      chk(route, (i >> 1) == 1 ? 2 : (i >> 1) == 2 ? 3 : i & 1);
      chk(pins, (i >> 1) == 1 || (i >> 1) == 2 ? 0 : 1 << (i & 1));
    end
  endtask

  task t_bits;
    bus(1, `ADDR_SOURCE_CLOCK, 32'h18);
    bus(1, `ADDR_BANDGAP, 32'h08);
    bus(1, `ADDR_START_STATUS, 32'h30);
    repeat (3) @(posedge clk);
    chk({refr, opa, bgp, pbuf, pwr}, 5'h1f);
    bus(1, `ADDR_SOURCE_CLOCK, 0);
    bus(1, `ADDR_BANDGAP, 0);
    bus(1, `ADDR_START_STATUS, 0);
    repeat (3) @(posedge clk);
    chk({refr, opa, bgp, pbuf, pwr, pins}, 0);
  endtask

  task t_conv;
    bus(1, `ADDR_IRQ_MASK, 1);
    bus(1, `ADDR_SOURCE_CLOCK, 1);
    bus(1, `ADDR_START_STATUS, 32'h20);
    bus(0, `ADDR_START_STATUS, 0);
    chk(rd, 32'h20);
    bus(1, `ADDR_START_STATUS, 32'ha0);
    bus(1, `ADDR_START_STATUS, 32'h20);
    t0 = $time;
    bus(0, `ADDR_START_STATUS, 0);
    chk(rd, 32'h60);
    #1 chk({smp, cnv}, 2'b10);
    for (i = 0; i < 1000 && irq !== 1'b1; i = i + 1)
      @(posedge clk) #1;
    chk(($time - t0) / 20, 28);
    bus(0, `ADDR_START_STATUS, 0);
    chk(rd, 32'h20);
    bus(0, `ADDR_RESULT_HIGH, 0);
    chk(rd, core_result[9:2]);
    bus(0, `ADDR_RESULT_LOW, 0);
    chk(rd, {core_result[1:0], 6'h0});
    bus(1, `ADDR_IRQ_MASK, 0);
    #1 chk(irq, 0);
    bus(1, `ADDR_IRQ_MASK, 1);
    #1 chk(irq, 1);
    bus(1, `ADDR_IRQ_STATUS, 1);
    #1 chk(irq, 0);
    bus(1, `ADDR_START_STATUS, 0);
    bus(0, `ADDR_RESULT_HIGH, 0);
    chk(rd, 0);
  endtask

  // main sequence
  initial
  begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    t_access;
    t_route;
    t_bits;
    t_conv;
    results;
  end
endmodule // adc_ctrl_tb
